// ==== core/bus_cycle_timing_clock_unit.sv ====
/*
 * bus cycle timing and clock unit: clocks, synchronous reset, strobes, waits.
 * assumes processor-side inputs arrive asynchronously and are synchronised here.
 */
// Contract
// R1: data buffer enable low enables data transceivers, high otherwise.
// R2: strobe enable low lets read and write strobes drive.
// R3: strobe enable high floats both strobes.
// R4: strobe enable high resynchronises phase one and double-rate clocks.
// R5: strobes decoded from direction; read low on read, write low on write.
// R6: processor holds direction low for read, high for write.
// R7: falling address strobe starts state T1.
// R8: reset input low drives reset output low.
// R9: reset output rises only on next phase-one rising edge.
// R10: ready low while wait states remain, high when extension ends.
// R11: phase clocks are two non-overlapping phases.
// R12: phase clocks run at half the source frequency.
// R13: double-rate clock runs at the source frequency.
// R14: logic-level clock follows phase one.
// R15: four-bit wait count selects zero to fifteen waits.
// R16: cycle hold between T1 and T2 before any control signal.
// R17: wait inputs weigh 1,2,4,8; low inputs count.
// R18: slow-cycle low inserts five waits and reshapes strobes.
// R19: state marker falls at T2 start, rises at T4 start.
// R20: hold input sampled end of T1 for hold, mid T2 for continuous wait.
// R21: no strobes or buffer enable while held between T1 and T2.
`timescale 1ns/1ps
module bus_cycle_timing_clock_unit #(
    parameter int SRC_DIVIDE = timing_unit_pkg::SRC_DIV
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // processor bus inputs
    input wire logic address_strobe_n_in,
    input wire logic direction_in,
    input wire logic strobe_enable_sync_in,
    input wire logic [timing_unit_pkg::WAIT_W-1:0] wait_count_inputs_n_in,
    input wire logic continuous_hold_n_in,
    input wire logic slow_cycle_n_in,
    input wire logic schmitt_reset_n_in,
    // clocks
    output logic phase_one_clock_out,
    output logic phase_two_clock_out,
    output logic double_rate_clock_out,
    output logic logic_level_phase_clock_out,
    // bus control
    output logic read_strobe_n_out,
    output logic read_strobe_oe_out,
    output logic write_strobe_n_out,
    output logic write_strobe_oe_out,
    output logic data_buffer_enable_n_out,
    output logic ready_out,
    output logic state_marker_out,
    output logic sync_reset_n_out
);
    import timing_unit_pkg::*;

    // two-stage synchronisers for every pin input
    localparam int NSYNC = 6 + WAIT_W;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    wire [NSYNC-1:0] raw_pins = {address_strobe_n_in, direction_in, strobe_enable_sync_in,
        continuous_hold_n_in, slow_cycle_n_in, schmitt_reset_n_in, wait_count_inputs_n_in};
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= {NSYNC{1'b1}};
            sync_b <= {NSYNC{1'b1}};
        end else begin
            sync_a <= raw_pins;
            sync_b <= sync_a;
        end
    end
    wire ads_n_s = sync_b[NSYNC-1];
    wire dir_s = sync_b[NSYNC-2];
    wire sen_s = sync_b[NSYNC-3];
    wire hold_n_s = sync_b[NSYNC-4];
    wire slow_n_s = sync_b[NSYNC-5];
    wire schmitt_reset_in_n_s = sync_b[NSYNC-6];
    wire [WAIT_W-1:0] waits_n_s = sync_b[WAIT_W-1:0];

    // source-rate enable from a divider
    logic [7:0] div_cnt;
    wire src_tick = (div_cnt == 8'(SRC_DIVIDE - 1));
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= src_tick ? 8'h00 : div_cnt + 8'h01;
        end
    end

    logic ph1_rise;
    logic ph2_rise;
    phase_clock_gen u_clk (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .src_tick_in(src_tick),
        .resync_in(sen_s), // [R4]
        .phase_one_clock_out(phase_one_clock_out),
        .phase_two_clock_out(phase_two_clock_out),
        .double_rate_clock_out(double_rate_clock_out),
        .logic_level_phase_clock_out(logic_level_phase_clock_out),
        .phase_one_rise_out(ph1_rise),
        .phase_two_rise_out(ph2_rise)
    );

    // reset output: low at once, released only on a phase-one rise
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_reset_n_out <= 1'b0;
        end else if (!schmitt_reset_in_n_s) begin
            sync_reset_n_out <= 1'b0; // [R8]
        end else if (ph1_rise) begin
            sync_reset_n_out <= 1'b1; // [R9]
        end
    end

    // address strobe fall detect, latched until the next phase-one edge
    logic ads_prev;
    logic ads_seen;
    wire ads_fall = ads_prev && !ads_n_s;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ads_prev <= 1'b1;
            ads_seen <= 1'b0;
        end else begin
            ads_prev <= ads_n_s;
            if (ads_fall) begin
                ads_seen <= 1'b1;
            end else if (ph1_rise) begin
                ads_seen <= 1'b0;
            end
        end
    end

    // bus cycle state machine, advancing on phase-one rises
    bus_state_t state;
    bus_state_t next_state;
    logic [3:0] waits_left;
    logic [3:0] next_waits;
    logic cont_wait;
    logic slow_cycle;
    logic is_write;
    // low inputs count: inverting the active-low pins gives the weighted sum
    wire [3:0] wait_sum = ~waits_n_s; // [R15] [R17]
    wire [3:0] load_waits = (!slow_n_s) ? SLOW_WAITS : wait_sum; // [R18]
    wire go = ads_fall || ads_seen;

    always_comb begin
        next_state = state;
        next_waits = waits_left;
        case (state)
            ST_IDLE: begin
                if (go) begin
                    next_state = ST_T1; // [R7]
                end
            end
            ST_T1: begin
                // hold pin sampled at end of T1 enters cycle hold
                next_state = (!hold_n_s) ? ST_HOLD : ST_T2; // [R16] [R20]
                next_waits = load_waits;
            end
            ST_HOLD: begin
                if (hold_n_s) begin
                    next_state = ST_T2; // [R16]
                    next_waits = load_waits;
                end
            end
            ST_T2: begin
                next_state = (waits_left != NO_WAITS || cont_wait) ? ST_TW : ST_T3;
            end
            ST_TW: begin
                if (cont_wait) begin
                    next_waits = waits_left; // [R20]
                end else if (waits_left > 4'h1) begin
                    next_waits = waits_left - 4'h1;
                end else begin
                    next_waits = NO_WAITS;
                    next_state = ST_T3;
                end
            end
            ST_T3: next_state = ST_T4;
            ST_T4: next_state = go ? ST_T1 : ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            waits_left <= NO_WAITS;
            cont_wait <= 1'b0;
            slow_cycle <= 1'b0;
            is_write <= 1'b0;
        end else if (!sync_reset_n_out) begin
            state <= ST_IDLE;
            waits_left <= NO_WAITS;
            cont_wait <= 1'b0;
        end else begin
            if (ph1_rise) begin
                state <= next_state;
                waits_left <= next_waits;
                if (state == ST_T1) begin
                    is_write <= dir_s; // [R6]
                    slow_cycle <= !slow_n_s;
                end
            end
            // continuous wait sampled mid-T2 on the phase-two rise
            if (ph2_rise && (state == ST_T2 || state == ST_TW)) begin
                cont_wait <= !hold_n_s; // [R20]
            end
        end
    end

    // strobe window: T2..T3, slow cycles drop the T2 part for setup
    wire in_data = (state == ST_T2 && !slow_cycle) || state == ST_TW || state == ST_T3;
    wire buf_on = state == ST_T2 || state == ST_TW || state == ST_T3; // [R21]
    wire extending = (state == ST_T2 && (waits_left != NO_WAITS || cont_wait)) ||
        (state == ST_TW && (cont_wait || waits_left > 4'h1));

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            read_strobe_oe_out <= 1'b0;
            write_strobe_oe_out <= 1'b0;
            data_buffer_enable_n_out <= 1'b1;
            ready_out <= 1'b1;
            state_marker_out <= 1'b1;
        end else begin
            read_strobe_n_out <= !(in_data && !is_write); // [R5] [R21]
            write_strobe_n_out <= !(in_data && is_write); // [R5] [R21]
            read_strobe_oe_out <= !sen_s; // [R2] [R3]
            write_strobe_oe_out <= !sen_s; // [R2] [R3]
            data_buffer_enable_n_out <= !buf_on; // [R1]
            ready_out <= !extending; // [R10]
            // low over T2..T3; registered from the state like the strobes, so the
            // marker never shows T4 while the strobes still show T3
            state_marker_out <= !buf_on; // [R19]
        end
    end
endmodule

// ==== core/phase_clock_gen.sv ====
/*
 * two-phase non-overlapping clock generator with double-rate and logic copy.
 * assumes a one-cycle source enable; sync input already synchronised.
 */
`timescale 1ns/1ps
module phase_clock_gen (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // control
    input wire logic src_tick_in,
    input wire logic resync_in,
    // clocks
    output logic phase_one_clock_out,
    output logic phase_two_clock_out,
    output logic double_rate_clock_out,
    output logic logic_level_phase_clock_out,
    output logic phase_one_rise_out,
    output logic phase_two_rise_out
);
    import timing_unit_pkg::*;
    logic [1:0] quarter;
    logic [1:0] next_quarter;
    // four source half-periods make one processor period: half the source rate
    assign next_quarter = resync_in ? PH_ONE : quarter + 2'h1; // [R4] [R12]
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            quarter <= PH_GAP2;
            phase_one_clock_out <= 1'b0;
            phase_two_clock_out <= 1'b0;
            double_rate_clock_out <= 1'b0;
            logic_level_phase_clock_out <= 1'b0;
            phase_one_rise_out <= 1'b0;
            phase_two_rise_out <= 1'b0;
        end else begin
            phase_one_rise_out <= 1'b0;
            phase_two_rise_out <= 1'b0;
            if (src_tick_in) begin
                quarter <= next_quarter;
                // gaps between phases keep them from overlapping
                phase_one_clock_out <= (next_quarter == PH_ONE); // [R11]
                phase_two_clock_out <= (next_quarter == PH_TWO); // [R11]
                double_rate_clock_out <= ~next_quarter[0]; // [R13]
                logic_level_phase_clock_out <= (next_quarter == PH_ONE); // [R14]
                // a held resync is no new rise, so bus states do not race through it
                phase_one_rise_out <= (next_quarter == PH_ONE) && (quarter != PH_ONE);
                phase_two_rise_out <= (next_quarter == PH_TWO);
            end
        end
    end
endmodule

// ==== core/timing_unit_pkg.sv ====
/*
 * constants for the bus cycle timing and clock unit.
 * assumes one system clock; all derived clocks are enable-paced registers.
 */
package timing_unit_pkg;
    localparam int WAIT_W = 4;
    localparam logic [3:0] SLOW_WAITS = 4'h5;
    localparam logic [3:0] NO_WAITS = 4'h0;
    // source divider: one source half-period per this many system cycles
    localparam int SRC_DIV = 2;
    localparam logic [1:0] PH_ONE = 2'h0;
    localparam logic [1:0] PH_GAP1 = 2'h1;
    localparam logic [1:0] PH_TWO = 2'h2;
    localparam logic [1:0] PH_GAP2 = 2'h3;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_T1 = 7'h02,
        ST_HOLD = 7'h04,
        ST_T2 = 7'h08,
        ST_TW = 7'h10,
        ST_T3 = 7'h20,
        ST_T4 = 7'h40
    } bus_state_t;
endpackage

// ==== verification/bus_cycle_timing_clock_unit_tb_top.sv ====
/* self-checking bench for the bus cycle timing and clock unit.
   assumes the processor bus model and the bound port checker. */
`timescale 1ns/1ps
module bus_cycle_timing_clock_unit_tb_top;
    import timing_unit_pkg::*;
    // source divide of two: a phase period is eight system clocks
    localparam int PERIOD = 8;
    logic clock_in = 1'b0, rst_n_in = 1'b0, go = 1'b0, write = 1'b0;
    logic strobe_enable_sync_in = 1'b0, continuous_hold_n_in = 1'b1, slow_cycle_n_in = 1'b1;
    logic schmitt_reset_n_in = 1'b1, address_strobe_n_in, direction_in;
    logic [WAIT_W-1:0] wait_count_inputs_n_in = 4'hF;
    logic phase_one_clock_out, phase_two_clock_out, double_rate_clock_out;
    logic logic_level_phase_clock_out, read_strobe_n_out, read_strobe_oe_out;
    logic write_strobe_n_out, write_strobe_oe_out, data_buffer_enable_n_out;
    logic ready_out, state_marker_out, sync_reset_n_out;
    int err_count = 0, checked = 0;
    always #4 clock_in = ~clock_in;
    bus_cycle_timing_clock_unit #(.SRC_DIVIDE(SRC_DIV)) DUT (.*);
    cpu_bus_model cpu (.clock_in, .go_in(go), .write_in(write), .marker_in(state_marker_out),
        .ads_n_out(address_strobe_n_in), .dir_out(direction_in));
    task automatic close_out();
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic cmp(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_n(input int got, input int exp, input string what);
        checked++;
        if (got != exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %0d", $time, what, got);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 400) begin
            cmp_n(n, 0, "wait timed out");
            close_out();
        end
    endtask
    task automatic wait_release();
        int n = 0;
        while (sync_reset_n_out !== 1'b1 && n < 400) begin
            n++;
            tick();
        end
        guard(n);
    endtask
    task automatic bus_cycle(input logic wr, input logic [WAIT_W-1:0] wn, input logic sl,
                             input int waits, input logic hd, input logic cw);
        int low = 0, rdy_low = 0, n = 0;
        write = wr;
        wait_count_inputs_n_in = wn;
        slow_cycle_n_in = sl;
        continuous_hold_n_in = !hd;
        go = 1'b1;
        tick();
        go = 1'b0;
        if (hd) begin
            tick(5 * PERIOD);
            cmp(state_marker_out, 1'b1, "held cycle reached T2");
            cmp(read_strobe_n_out & write_strobe_n_out & data_buffer_enable_n_out, 1'b1,
                "control active while held");
            continuous_hold_n_in = 1'b1;
        end
        while (state_marker_out !== 1'b0 && n < 400) begin
            n++;
            tick();
        end
        guard(n);
        // continuous wait: pin low from T2 entry, caught by the mid-T2 sample
        if (cw) continuous_hold_n_in = 1'b0;
        while (state_marker_out === 1'b0 && low < 400) begin
            if (low == 12) begin
                continuous_hold_n_in = 1'b1;
                cmp(read_strobe_n_out, wr, "read strobe");
                cmp(write_strobe_n_out, !wr, "write strobe");
                cmp(data_buffer_enable_n_out, 1'b0, "buffer enable");
            end
            if (ready_out === 1'b0) rdy_low++;
            low++;
            tick();
        end
        guard(low);
        cmp_n(low, (waits + 2) * PERIOD, "T2 to T4 length");
        cmp_n(int'(rdy_low > 0), int'(waits > 0), "ready extension");
        wait_count_inputs_n_in = 4'hF;
        slow_cycle_n_in = 1'b1;
        tick(PERIOD);
    endtask
    task automatic clock_check();
        logic p1, p2, pf;
        int r1 = 0, r2 = 0, rf = 0;
        p1 = phase_one_clock_out;
        p2 = phase_two_clock_out;
        pf = double_rate_clock_out;
        repeat (4 * PERIOD) begin
            tick();
            if (!p1 && phase_one_clock_out) r1++;
            if (!p2 && phase_two_clock_out) r2++;
            if (!pf && double_rate_clock_out) rf++;
            p1 = phase_one_clock_out;
            p2 = phase_two_clock_out;
            pf = double_rate_clock_out;
        end
        cmp_n(r1, 4, "phase one rate");
        cmp_n(r2, 4, "phase two rate");
        cmp_n(rf, 8, "double rate");
    endtask
    task automatic float_check();
        strobe_enable_sync_in = 1'b1;
        tick(PERIOD);
        cmp(read_strobe_oe_out | write_strobe_oe_out, 1'b0, "strobes floated");
        // a standing sync level keeps the phase counter parked on phase one
        cmp(phase_one_clock_out, 1'b1, "phase one held by sync");
        cmp(double_rate_clock_out, 1'b1, "double rate held by sync");
        strobe_enable_sync_in = 1'b0;
        tick(PERIOD);
        cmp(read_strobe_oe_out & write_strobe_oe_out, 1'b1, "strobes driven");
    endtask
    task automatic wait_scan();
        int counts[6] = '{0, 1, 2, 4, 8, 15};
        foreach (counts[i]) bus_cycle(i[0], ~4'(counts[i]), 1'b1, counts[i], 1'b0, 1'b0);
    endtask
    task automatic reset_check();
        schmitt_reset_n_in = 1'b0;
        tick(6);
        cmp(sync_reset_n_out, 1'b0, "reset output low");
        schmitt_reset_n_in = 1'b1;
        wait_release();
        cmp(phase_one_clock_out, 1'b1, "reset released at phase one");
    endtask
    initial begin
        tick(3);
        rst_n_in = 1'b1;
        wait_release();
        clock_check();
        float_check();
        wait_scan();
        bus_cycle(1'b0, 4'hF, 1'b0, int'(SLOW_WAITS), 1'b0, 1'b0);
        bus_cycle(1'b1, 4'hF, 1'b1, 0, 1'b1, 1'b0);
        // pin low for twelve clocks from T2 spans two phase-two samples: two waits
        bus_cycle(1'b0, 4'hF, 1'b1, 2, 1'b0, 1'b1);
        reset_check();
        close_out();
    end
endmodule

// ==== verification/cpu_bus_model.sv ====
/* processor side bus model: starts one bus cycle per request.
   assumes the unit's state marker shows that T2 has begun. */
`timescale 1ns/1ps
module cpu_bus_model (
    // control from the bench
    input wire logic clock_in,
    input wire logic go_in,
    input wire logic write_in,
    input wire logic marker_in,
    // bus pins
    output logic ads_n_out,
    output logic dir_out
);
    initial begin
        ads_n_out = 1'b1;
        dir_out = 1'b0;
    end
    // direction stands until the next request, so it covers the whole cycle
    always @(posedge clock_in) begin
        if (go_in) begin
            ads_n_out <= #1 1'b0;
            dir_out <= #1 write_in;
        end else if (!marker_in) begin
            ads_n_out <= #1 1'b1;
        end
    end
endmodule

// ==== verification/timing_unit_monitor.sv ====
/* port checker for the bus cycle timing and clock unit.
   assumes it is bound to the top module and sees one clock domain. */
`timescale 1ns/1ps
module timing_unit_monitor (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic strobe_enable_sync_in,
    input wire logic schmitt_reset_n_in,
    input wire logic phase_one_clock_out,
    input wire logic phase_two_clock_out,
    input wire logic logic_level_phase_clock_out,
    input wire logic read_strobe_n_out,
    input wire logic read_strobe_oe_out,
    input wire logic write_strobe_n_out,
    input wire logic write_strobe_oe_out,
    input wire logic data_buffer_enable_n_out,
    input wire logic state_marker_out,
    input wire logic sync_reset_n_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    phase_gap_a: assert property (!(phase_one_clock_out && phase_two_clock_out))
        else $error("phase clocks overlap");
    ttl_copy_a: assert property (
        $rose(phase_one_clock_out) |-> ##[0:1] logic_level_phase_clock_out)
        else $error("logic clock does not follow phase one");
    // six cycles cover the input synchroniser and the output register
    float_off_a: assert property (
        strobe_enable_sync_in [*6] |-> !read_strobe_oe_out && !write_strobe_oe_out)
        else $error("strobes driven while disabled");
    drive_on_a: assert property (
        !strobe_enable_sync_in [*6] |-> read_strobe_oe_out && write_strobe_oe_out)
        else $error("strobes floated while enabled");
    reset_out_a: assert property (
        !schmitt_reset_n_in [*4] |-> !sync_reset_n_out) else $error("reset output not low");
    reset_edge_a: assert property (
        $rose(sync_reset_n_out) |-> phase_one_clock_out) else $error("reset released off phase");
    strobe_excl_a: assert property (
        !(!read_strobe_n_out && !write_strobe_n_out)) else $error("both strobes active");
    buffer_state_a: assert property (
        !data_buffer_enable_n_out |-> !state_marker_out) else $error("buffer on outside cycle");
    strobe_state_a: assert property (
        !read_strobe_n_out || !write_strobe_n_out |-> !state_marker_out)
        else $error("strobe outside cycle");
endmodule
bind bus_cycle_timing_clock_unit timing_unit_monitor mon (.*);
